/* File: logic/pdm_consts.vh */
// Constants for the power-down mode controller: offsets, fields, resets and timing.
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// Register byte offsets on the Avalon-MM slave.
`define PDM_OFS_SYSCTL_ONE 4'h0
`define PDM_OFS_SYSCTL_TWO 4'h4
`define PDM_OFS_MSTOP_TWO 4'h8
`define PDM_OFS_STATUS 4'hC

// Field positions of system_control_one.
`define PDM_STANDBY_SEL_BIT 7
`define PDM_WAKE_WAIT_HI 6
`define PDM_WAKE_WAIT_LO 4

// Field positions of system_control_two.
`define PDM_SLEEP_MODE_SEL_BIT 7
`define PDM_DIRECT_TRANS_BIT 5
`define PDM_ACT_CLK_HI 4
`define PDM_ACT_CLK_LO 2

// Field position of module_stop_control_two.
`define PDM_TIMER_B1_STBY_BIT 4

// Reset values of the writable registers.
`define PDM_RST_SYSCTL_ONE 8'h00
`define PDM_RST_SYSCTL_TWO 8'h00
`define PDM_RST_MSTOP_TWO 8'h00

// Writable bit masks; every other bit reads as zero.
`define PDM_MASK_SYSCTL_ONE 8'hF0
`define PDM_MASK_SYSCTL_TWO 8'hBC
`define PDM_MASK_MSTOP_TWO 8'h10

// Operating clock divider ratios.
`define PDM_DIV_16 7'h10
`define PDM_DIV_32 7'h20
`define PDM_DIV_64 7'h40

// Clock rate and timing figures.
`define PDM_CLOCK_MHZ 10
`define PDM_POR_TIME_US 100
`define PDM_WAKE_WAIT_BASE 16'h0010
`define PDM_POR_WAIT_CYCLES 16'h03E8

// Mode codes shown in the status register.
`define PDM_MODE_ACTIVE 3'h0
`define PDM_MODE_SLEEP 3'h1
`define PDM_MODE_SUBSLEEP 3'h2
`define PDM_MODE_STANDBY 3'h3
`define PDM_MODE_WAKE_WAIT 3'h4
`define PDM_MODE_RESET_HOLD 3'h5
`define PDM_MODE_POR_WAIT 3'h6

`endif

/* File: logic/pdm_clk_div.v */
// Operating clock divider that turns the clock select code into a tick.
`timescale 1ns/1ps
`include "pdm_consts.vh"

module pdm_clk_div (
  // Clock and reset.
  input wire clock,
  input wire reset,
  // Selected operating clock code.
  input wire [2:0] divSel,
  // One-cycle enable at the operating frequency.
  output reg tickReg
);

  reg [6:0] countReg;
  reg [6:0] divisor;

  // Decode the select code; codes 0xx and 100 run undivided.
  always @* begin
    case (divSel)
      3'h5: divisor = `PDM_DIV_16;
      3'h6: divisor = `PDM_DIV_32;
      3'h7: divisor = `PDM_DIV_64;
      default: divisor = 7'h01;
    endcase
  end

  // Counting down; a count at or above a new smaller ratio reloads at once with a tick, so spacing is not kept.
  always @(posedge clock) begin
    if (reset) begin
      countReg <= 7'h00;
      tickReg <= 1'b0;
    end else if (countReg == 7'h00 || countReg >= divisor) begin
      countReg <= divisor - 7'h01;
      tickReg <= 1'b1;
    end else begin
      countReg <= countReg - 7'h01;
      tickReg <= 1'b0;
    end
  end

endmodule // pdm_clk_div

/* File: logic/pdm_controller.v */
// Power-down mode controller with its Avalon-MM register slave.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pdm_consts.vh"

// Function
// - Timer B1 standby bit stops its clock.
// - Reserved stop-register bits read zero.
// - Sleep instruction decodes sleep, subsleep, standby.
// - Direct transition stays active, new frequency.
// - Disabled direct interrupt falls back to sleep.
// - Masked direct attempt enters unwakeable sleep.
// - Transition with subsleep select resets three peripherals.
// - Sleep halts CPU, peripherals keep clocking.
// - Interrupt in sleep wakes at once.
// - Masked or disabled interrupts never wake.
// - Reset pin low in sleep resets CPU.
// - Standby halts oscillator; ports float.
// - Deep wake waits selected oscillator settle time.
// - Subsleep halts oscillator; ports hold levels.
// - Reset from deep mode waits power-on time.
// - Clock select applies after next sleep.
// - Deep modes reset three, retain others.
// - Clock select codes map to divide ratios.
module pdm_controller #(
  // Power-on settle count in clock cycles; the default spans 100 us at 10 MHz.
  parameter [15:0] POR_WAIT_CYCLES = `PDM_POR_WAIT_CYCLES
) (
  // Clock and synchronous reset.
  input wire clock,
  input wire reset,
  // Avalon-MM register slave.
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // CPU core side.
  input wire sleepExec,
  input wire interruptMaskBit,
  input wire irqPending,
  input wire directTransIntEnable,
  // External reset pin, asynchronous to the clock.
  input wire externalReset_n,
  // Clock and power controls.
  output reg oscEnableReg,
  output reg cpuHaltReg,
  output reg cpuResetReg,
  output reg periphHaltReg,
  output reg periphTickReg,
  output reg timerB1StopReg,
  output reg tvSciAdcResetReg,
  output reg ioHighZReg,
  output reg ioHoldReg,
  // Exception starts and mode.
  output reg intExceptionStartReg,
  output reg resetExceptionStartReg,
  output reg [2:0] modeReg
);

  // Register state.
  reg [7:0] sysCtlOneReg;
  reg [7:0] sysCtlTwoReg;
  reg [7:0] mStopTwoReg;
  reg [2:0] activeClkReg;

  // Sequencer state, counters and their next values.
  reg [2:0] stateReg;
  reg [2:0] stateNext;
  reg [15:0] countReg;
  reg [15:0] countNext;
  reg fromDeepReg;
  reg fromDeepNext;
  reg periphPulseNext;
  reg intStartNext;
  reg rstStartNext;
  reg [2:0] activeClkNext;

  // Pin synchroniser, bus read byte and the divided tick.
  reg resetSync1Reg;
  reg resetSync2Reg;
  reg [7:0] readByte;
  wire divTick;

  // Register fields and the conditions the sequencer decodes.
  wire standbySel = sysCtlOneReg[`PDM_STANDBY_SEL_BIT];
  wire [2:0] wakeWaitSel = sysCtlOneReg[`PDM_WAKE_WAIT_HI:`PDM_WAKE_WAIT_LO];
  wire sleepModeSel = sysCtlTwoReg[`PDM_SLEEP_MODE_SEL_BIT];
  wire directTrans = sysCtlTwoReg[`PDM_DIRECT_TRANS_BIT];
  wire [2:0] actClkSel = sysCtlTwoReg[`PDM_ACT_CLK_HI:`PDM_ACT_CLK_LO];
  // The pin is read only after its second flip-flop.
  wire pinLow = ~resetSync2Reg;
  // Enable-bit gating happens at the source, so only the mask bit is applied here.
  wire wakeReq = irqPending & ~interruptMaskBit;
  wire [15:0] wakeWaitCycles = `PDM_WAKE_WAIT_BASE << wakeWaitSel;
  wire busReq = read | write;

  // The pin crosses into the clock domain through two flip-flops.
  // Both stages reset high, the idle pin level, so leaving reset is not a pin event.
  always @(posedge clock) begin
    if (reset) begin
      resetSync1Reg <= 1'b1;
      resetSync2Reg <= 1'b1;
    end else begin
      resetSync1Reg <= externalReset_n;
      resetSync2Reg <= resetSync1Reg;
    end
  end

  // Read mux; only defined bits are returned, reserved ones stay zero.
  always @* begin
    case (address)
      `PDM_OFS_SYSCTL_ONE: readByte = sysCtlOneReg;
      `PDM_OFS_SYSCTL_TWO: readByte = sysCtlTwoReg;
      `PDM_OFS_MSTOP_TWO: readByte = mStopTwoReg & `PDM_MASK_MSTOP_TWO;
      // Status shows the committed clock code, not the one waiting in the register.
      `PDM_OFS_STATUS: readByte = {2'h0, activeClkReg, stateReg};
      default: readByte = 8'h00;
    endcase
  end

  // Bus slave: one wait cycle, the transfer completes at the edge waitrequest is low.
  // Reads and writes share one fixed latency, which keeps the master simple.
  always @(posedge clock) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
      sysCtlOneReg <= `PDM_RST_SYSCTL_ONE;
      sysCtlTwoReg <= `PDM_RST_SYSCTL_TWO;
      mStopTwoReg <= `PDM_RST_MSTOP_TWO;
    end else if (busReq && waitrequest) begin
      waitrequest <= 1'b0;
      readdata <= {24'h000000, readByte};
    end else begin
      waitrequest <= 1'b1;
      if (write && !waitrequest && byteenable[0]) begin
        case (address)
          `PDM_OFS_SYSCTL_ONE: sysCtlOneReg <= writedata[7:0] & `PDM_MASK_SYSCTL_ONE;
          `PDM_OFS_SYSCTL_TWO: sysCtlTwoReg <= writedata[7:0] & `PDM_MASK_SYSCTL_TWO;
          `PDM_OFS_MSTOP_TWO: mStopTwoReg <= writedata[7:0] & `PDM_MASK_MSTOP_TWO;
          // The status slot is read-only and unmapped slots are dropped.
          default: mStopTwoReg <= mStopTwoReg;
        endcase
      end
    end
  end

  // Mode sequencer: decides the next mode from the mode bits caught at the sleep instruction.
  always @* begin
    stateNext = stateReg;
    countNext = countReg;
    fromDeepNext = fromDeepReg;
    activeClkNext = activeClkReg;
    periphPulseNext = 1'b0;
    intStartNext = 1'b0;
    rstStartNext = 1'b0;
    if (pinLow) begin
      // The pin overrides every mode; deep modes restart the oscillator first.
      if (stateReg == `PDM_MODE_STANDBY || stateReg == `PDM_MODE_SUBSLEEP ||
          stateReg == `PDM_MODE_WAKE_WAIT) begin
        fromDeepNext = 1'b1;
      end
      stateNext = `PDM_MODE_RESET_HOLD;
    end else begin
      case (stateReg)
        `PDM_MODE_ACTIVE: begin
          if (sleepExec) begin
            // The mode is chosen from the bits as they stand at this edge only.
            // Operating clock changes only here, never on the register write.
            activeClkNext = actClkSel;
            // A transition made with the subsleep select set clears three peripherals.
            periphPulseNext = sleepModeSel;
            if (directTrans && directTransIntEnable && !interruptMaskBit) begin
              stateNext = `PDM_MODE_ACTIVE;
            end else if (directTrans) begin
              // Fallback; with the mask set no interrupt can wake it later.
              stateNext = sleepModeSel ? `PDM_MODE_SUBSLEEP : `PDM_MODE_SLEEP;
            end else if (standbySel) begin
              stateNext = `PDM_MODE_STANDBY;
            end else begin
              stateNext = sleepModeSel ? `PDM_MODE_SUBSLEEP : `PDM_MODE_SLEEP;
            end
          end
        end
        // The oscillator still runs, so an unmasked request wakes on the next edge.
        `PDM_MODE_SLEEP: begin
          if (wakeReq) begin
            stateNext = `PDM_MODE_ACTIVE;
            intStartNext = 1'b1;
          end
        end
        // Deep modes let the restarted oscillator settle before any instruction runs.
        `PDM_MODE_SUBSLEEP, `PDM_MODE_STANDBY: begin
          if (wakeReq) begin
            stateNext = `PDM_MODE_WAKE_WAIT;
            countNext = wakeWaitCycles;
          end
        end
        // A pin reset during the settle wait is taken by the override above.
        `PDM_MODE_WAKE_WAIT: begin
          if (countReg <= 16'h0001) begin
            stateNext = `PDM_MODE_ACTIVE;
            intStartNext = 1'b1;
          end else begin
            countNext = countReg - 16'h0001;
          end
        end
        `PDM_MODE_RESET_HOLD: begin
          // Pin has risen; deep modes wait out the power-on settle time.
          if (fromDeepReg) begin
            stateNext = `PDM_MODE_POR_WAIT;
            countNext = POR_WAIT_CYCLES;
          end else begin
            stateNext = `PDM_MODE_ACTIVE;
            rstStartNext = 1'b1;
          end
          fromDeepNext = 1'b0;
        end
        // The CPU stays in reset until the power-on count runs out.
        `PDM_MODE_POR_WAIT: begin
          if (countReg <= 16'h0001) begin
            stateNext = `PDM_MODE_ACTIVE;
            rstStartNext = 1'b1;
          end else begin
            countNext = countReg - 16'h0001;
          end
        end
        // An unused code returns to active rather than locking the chip up.
        default: stateNext = `PDM_MODE_ACTIVE;
      endcase
    end
  end

  // Sequencer state.
  always @(posedge clock) begin
    if (reset) begin
      stateReg <= `PDM_MODE_ACTIVE;
      countReg <= 16'h0000;
      fromDeepReg <= 1'b0;
      activeClkReg <= 3'h0;
    end else begin
      stateReg <= stateNext;
      countReg <= countNext;
      fromDeepReg <= fromDeepNext;
      activeClkReg <= activeClkNext;
    end
  end

  // Operating clock tick from the committed select code.
  // A smaller ratio reloads the count at once, so its first tick may come early.
  pdm_clk_div pdm_clk_div_inst (
    .clock(clock),
    .reset(reset),
    .divSel(activeClkReg),
    .tickReg(divTick)
  );

  // Control outputs registered from the next mode so they line up with modeReg.
  always @(posedge clock) begin
    if (reset) begin
      modeReg <= `PDM_MODE_ACTIVE;
      oscEnableReg <= 1'b1;
      cpuHaltReg <= 1'b0;
      cpuResetReg <= 1'b0;
      periphHaltReg <= 1'b0;
      periphTickReg <= 1'b0;
      timerB1StopReg <= 1'b0;
      tvSciAdcResetReg <= 1'b0;
      ioHighZReg <= 1'b0;
      ioHoldReg <= 1'b0;
      intExceptionStartReg <= 1'b0;
      resetExceptionStartReg <= 1'b0;
    end else begin
      modeReg <= stateNext;
      // Oscillator off only while parked in a deep mode; wake and reset restart it.
      oscEnableReg <= !(stateNext == `PDM_MODE_STANDBY ||
                        stateNext == `PDM_MODE_SUBSLEEP);
      // Every mode but active stops instruction fetch; registers keep their contents.
      cpuHaltReg <= stateNext != `PDM_MODE_ACTIVE;
      cpuResetReg <= stateNext == `PDM_MODE_RESET_HOLD ||
                     stateNext == `PDM_MODE_POR_WAIT;
      periphHaltReg <= stateNext == `PDM_MODE_STANDBY ||
                       stateNext == `PDM_MODE_SUBSLEEP ||
                       stateNext == `PDM_MODE_WAKE_WAIT;
      // Peripherals keep the divided clock in sleep but not in deep modes.
      periphTickReg <= divTick && (stateNext == `PDM_MODE_ACTIVE ||
                                   stateNext == `PDM_MODE_SLEEP);
      // Timer B1 standby follows its stop bit one cycle after the write lands.
      timerB1StopReg <= mStopTwoReg[`PDM_TIMER_B1_STBY_BIT];
      tvSciAdcResetReg <= periphPulseNext || stateNext == `PDM_MODE_STANDBY ||
                          stateNext == `PDM_MODE_SUBSLEEP;
      // Standby floats the ports while subsleep holds their levels.
      ioHighZReg <= stateNext == `PDM_MODE_STANDBY;
      ioHoldReg <= stateNext == `PDM_MODE_SUBSLEEP;
      // Exception starts are single-cycle strobes toward the CPU core.
      intExceptionStartReg <= intStartNext;
      resetExceptionStartReg <= rstStartNext;
    end
  end

endmodule // pdm_controller

/* File: sim/pdm_controller_asserts.sv */
// Concurrent checks on the ports of the power-down mode controller.
`timescale 1ns/1ps
module pdm_controller_asserts (
  // Clock, reset and register bus.
  input wire clock,
  input wire reset,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  // CPU side and power controls.
  input wire interruptMaskBit,
  input wire irqPending,
  input wire externalReset_n,
  input wire oscEnableReg,
  input wire cpuHaltReg,
  input wire periphHaltReg,
  input wire timerB1StopReg,
  input wire tvSciAdcResetReg,
  input wire ioHighZReg,
  input wire intExceptionStartReg,
  input wire [2:0] modeReg
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  AST_TB1_STOP: assert property (write && !waitrequest && address == 4'h8 && byteenable[0]
    && writedata[4] |-> ##[1:2] timerB1StopReg) else $error("Timer stop bit not applied.");
  AST_RSV_ZERO: assert property (read && !waitrequest && address == 4'h8
    |-> readdata[7:5] == 3'h0 && readdata[3:0] == 4'h0) else $error("Reserved bits not zero.");
  AST_SLEEP_RUN: assert property (modeReg == 3'h1
    |-> oscEnableReg && cpuHaltReg && !periphHaltReg) else $error("Sleep controls wrong.");
  AST_STBY_HALT: assert property (modeReg == 3'h3 |-> !oscEnableReg && periphHaltReg
    && ioHighZReg && tvSciAdcResetReg) else $error("Standby controls wrong.");
  AST_SUBSLP_HALT: assert property (modeReg == 3'h2 |-> !oscEnableReg && periphHaltReg
    && !ioHighZReg && tvSciAdcResetReg) else $error("Subsleep controls wrong.");
  AST_SLEEP_WAKE: assert property (modeReg == 3'h1 && irqPending && !interruptMaskBit
    && externalReset_n |=> modeReg == 3'h0 && intExceptionStartReg) else $error("Sleep wake late.");
  // The pin history keeps a synchronised reset from counting as a wake.
  AST_MASK_HOLD: assert property (interruptMaskBit && externalReset_n && $past(externalReset_n, 3)
    && modeReg != 3'h0 && modeReg < 3'h4 |=> $stable(modeReg)) else $error("Masked wake.");
  AST_WAKE_WAIT: assert property ($rose(modeReg == 3'h4)
    |-> (modeReg == 3'h4) [*8] ##[8:1000] intExceptionStartReg) else $error("Wake wait wrong.");

  // Main scenarios reached.
  cover property (modeReg == 3'h3 ##1 modeReg == 3'h4);
  cover property ($rose(intExceptionStartReg));
  cover property (read && !waitrequest && address == 4'h8);
endmodule // pdm_controller_asserts

bind pdm_controller pdm_controller_asserts pdm_controller_asserts_inst (.clock(clock),
  .reset(reset), .address(address), .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .interruptMaskBit(interruptMaskBit), .irqPending(irqPending),
  .externalReset_n(externalReset_n), .oscEnableReg(oscEnableReg), .cpuHaltReg(cpuHaltReg),
  .periphHaltReg(periphHaltReg), .timerB1StopReg(timerB1StopReg),
  .tvSciAdcResetReg(tvSciAdcResetReg), .ioHighZReg(ioHighZReg),
  .intExceptionStartReg(intExceptionStartReg), .modeReg(modeReg));

/* File: sim/pdm_cpu_model.sv */
// Behavioural CPU core issuing sleep, interrupt and reset pin requests.
`timescale 1ns/1ps
module pdm_cpu_model #(
  parameter PIN_LOW_CYCLES = 6
) (
  // Clock, reset and bench requests.
  input wire clock,
  input wire reset,
  input wire sleepGo,
  input wire irqGo,
  input wire pinGo,
  input wire intExceptionStartReg,
  // Requests toward the controller.
  output reg sleepExec = 1'b0,
  output reg irqPending = 1'b0,
  output reg externalReset_n = 1'b1
);
  integer pinCount = 0;
  // An interrupt stays requested until its exception starts, as a real source does.
  always @(posedge clock) begin
    sleepExec <= sleepGo & ~reset;
    if (reset || intExceptionStartReg)
      irqPending <= 1'b0;
    else if (irqGo)
      irqPending <= 1'b1;
    if (pinGo)
      pinCount <= PIN_LOW_CYCLES;
    else if (pinCount > 0)
      pinCount <= pinCount - 1;
    externalReset_n <= !(pinGo || pinCount > 1);
  end
endmodule // pdm_cpu_model

/* File: sim/pdm_controller_tb.sv */
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_controller_tb;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg [3:0] address = 4'h0;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [3:0] byteenable = 4'hF;
  reg [31:0] writedata = 32'h0;
  reg interruptMaskBit = 1'b0;
  reg directTransIntEnable = 1'b0;
  reg sleepGo = 1'b0;
  reg irqGo = 1'b0;
  reg pinGo = 1'b0;
  wire [31:0] readdata;
  wire [2:0] modeReg;
  wire waitrequest, sleepExec, irqPending, externalReset_n, oscEnableReg, cpuHaltReg;
  wire cpuResetReg, periphHaltReg, periphTickReg, timerB1StopReg, tvSciAdcResetReg;
  wire ioHighZReg, ioHoldReg, intExceptionStartReg, resetExceptionStartReg;
  integer seed = 86;
  integer miscompares = 0;
  integer n_tests = 0;
  integer cycles = 0;
  integer i, k, prev, cnt, em, saw;
  reg [31:0] r;
  reg [7:0] rd;
  reg [3:0] row;
  // Rows of {direct, standby, subsleep select, direct interrupt enable}.
  reg [19:0] rows = 20'hA_D_5_3_1;

  pdm_controller #(.POR_WAIT_CYCLES(16'h0008)) pdm_controller_inst (.clock(clock),
    .reset(reset), .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .sleepExec(sleepExec), .interruptMaskBit(interruptMaskBit), .irqPending(irqPending),
    .directTransIntEnable(directTransIntEnable), .externalReset_n(externalReset_n),
    .oscEnableReg(oscEnableReg), .cpuHaltReg(cpuHaltReg), .cpuResetReg(cpuResetReg),
    .periphHaltReg(periphHaltReg), .periphTickReg(periphTickReg),
    .timerB1StopReg(timerB1StopReg), .tvSciAdcResetReg(tvSciAdcResetReg),
    .ioHighZReg(ioHighZReg), .ioHoldReg(ioHoldReg),
    .intExceptionStartReg(intExceptionStartReg),
    .resetExceptionStartReg(resetExceptionStartReg), .modeReg(modeReg));
  pdm_cpu_model pdm_cpu_model_inst (.clock(clock), .reset(reset), .sleepGo(sleepGo),
    .irqGo(irqGo), .pinGo(pinGo), .intExceptionStartReg(intExceptionStartReg),
    .sleepExec(sleepExec), .irqPending(irqPending), .externalReset_n(externalReset_n));

  // Free-running clock at 100 ns.
  initial forever #50 clock = ~clock;

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask

  task results;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  // One bus cycle; the request is held until waitrequest is seen low at an edge.
  task bus(input w, input [3:0] a, input [7:0] dat, input be);
    begin
      @(posedge clock);
      r = $random(seed);
      read <= !w;
      write <= w;
      address <= a;
      byteenable <= {r[27:25], be};
      writedata <= {r[23:0], dat};
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask

  // A one-cycle request through the CPU model, then time for it to land.
  task pulse(input integer which, input integer settle);
    begin
      @(posedge clock);
      if (which == 0) sleepGo <= 1'b1;
      else if (which == 1) irqGo <= 1'b1;
      else pinGo <= 1'b1;
      @(posedge clock);
      sleepGo <= 1'b0;
      irqGo <= 1'b0;
      pinGo <= 1'b0;
      repeat (settle) @(posedge clock);
    end
  endtask

  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      results;
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    // Reset values, status and an unmapped slot all read zero.
    for (i = 0; i < 5; i = i + 1) begin
      bus(0, (i == 4) ? 4'hE : i * 4, 8'h00, 1'b1);
      chk(rd, 0);
    end
    // Random data read back through each writable mask.
    for (i = 0; i < 3; i = i + 1) begin
      k = $random(seed);
      bus(1, i * 4, k[7:0], 1'b1);
      bus(0, i * 4, 8'h00, 1'b1);
      chk(rd, k[7:0] & (i == 0 ? `PDM_MASK_SYSCTL_ONE : i == 1 ? 8'hBC : 8'h10));
    end
    bus(1, 4'h8, 8'hFF, 1'b1);
    bus(1, 4'h8, 8'h00, 1'b0);
    bus(1, 4'hE, 8'h00, 1'b1);
    bus(0, 4'h8, 8'h00, 1'b1);
    chk(rd, 8'h10);
    chk(timerB1StopReg, 1);
    bus(1, 4'h8, 8'hEF, 1'b1);
    repeat (2) @(posedge clock);
    chk(timerB1StopReg, 0);
    // Direct transitions through clock codes 0, 5, 6 and 7; the new code waits for sleep.
    directTransIntEnable <= 1'b1;
    prev = 0;
    for (i = 0; i < 4; i = i + 1) begin
      k = (i == 0) ? 0 : i + 4;
      bus(1, 4'h4, 8'h20 | k[7:0] << 2, 1'b1);
      bus(0, 4'hC, 8'h00, 1'b1);
      chk(rd, prev << 3);
      pulse(0, 4);
      chk(modeReg, `PDM_MODE_ACTIVE);
      bus(0, 4'hC, 8'h00, 1'b1);
      chk(rd, k << 3);
      prev = k;
      cnt = 0;
      repeat (64) begin
        @(posedge clock);
        cnt = cnt + periphTickReg;
      end
      chk(cnt, (i == 0) ? 64 : 64 >> (i + 3));
    end
    // Mode table entered masked; the mask keeps every mode, its release wakes.
    for (i = 0; i < 5; i = i + 1) begin
      row = rows[4 * i +: 4];
      em = (!row[3] && row[2]) ? 3 : row[1] ? 2 : 1;
      bus(1, 4'h0, {row[2], 7'h00}, 1'b1);
      bus(1, 4'h4, {row[1], 1'b0, row[3], 5'h00}, 1'b1);
      directTransIntEnable <= row[0];
      interruptMaskBit <= 1'b1;
      pulse(0, 4);
      chk(modeReg, em);
      chk(tvSciAdcResetReg, em > 1);
      chk(cpuHaltReg, 1);
      chk(oscEnableReg, em == 1);
      chk(ioHighZReg, em == 3);
      chk(ioHoldReg, em == 2);
      pulse(1, 30);
      chk(modeReg, em);
      interruptMaskBit <= 1'b0;
      cnt = 0;
      do begin
        @(posedge clock);
        cnt = cnt + 1;
      end while (modeReg !== `PDM_MODE_ACTIVE && cnt < 200);
      chk(em > 1 ? cnt >= 16 : cnt <= 3, 1);
    end
    // Direct transition with its interrupt disabled and the mask clear falls back to sleep.
    directTransIntEnable <= 1'b0;
    bus(1, 4'h4, 8'h20, 1'b1);
    pulse(0, 4);
    chk(modeReg, `PDM_MODE_SLEEP);
    pulse(1, 2);
    chk(modeReg, `PDM_MODE_ACTIVE);
    chk(intExceptionStartReg, 1);
    // Reset pin in sleep, then in standby where the power-on wait follows.
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, 4'h0, {i[0], 7'h00}, 1'b1);
      bus(1, 4'h4, 8'h00, 1'b1);
      pulse(0, 2);
      pulse(2, 0);
      saw = 0;
      cnt = 0;
      do begin
        @(posedge clock);
        cnt = cnt + 1;
        saw = saw | (cpuResetReg === 1'b1) | 2 * (modeReg === `PDM_MODE_POR_WAIT);
      end while (resetExceptionStartReg !== 1'b1 && cnt < 300);
      chk(saw, 2 * i + 1);
      chk(modeReg, `PDM_MODE_ACTIVE);
    end
    results;
  end
endmodule // pdm_controller_tb
